// ### hdl/dct_clock_time_base.sv
// Clock source selection and time base divider with an AXI4-Lite register slave
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// R1: Select bit picks crystal or RC clock
// R2: Reset clears select, crystal drives clock
// R3: RC oscillator enabled only when selected/test
// R4: Crystal oscillator always kept running
// R5: Select bit also raises logic supply
// R6: Software sets boost, waits 1 ms
// R7: Software clears boost before slow clock
// R8: Select register is 4 bits, bit 0
// R9: Fifteen stage divider runs from crystal
// R10: Divider starts at zero, counts falling edges
// R11: Ticks on falling 256/32/16/4/1 Hz
// R12: 16 Hz tap clocks the watchdog
// R13: Buzzer gets 1/8/16 Hz, 2/4 kHz
// R14: 64 Hz tap samples input ports
// R15: Reset circuit gets 1 Hz, 8 Hz
// R16: Capture gets 256/128/64/32 Hz taps
// R17: Status read returns 1/2/4/8 Hz stages
// R18: Any status write clears 8..1 Hz stages
// R19: Cleared 4 Hz or 1 Hz stage that was one raises tick
// R20: Software masks interrupt before clearing stages
// R21: Status register is 4 bits at 0FH
// R22: Each tick sets its own request flag
// R23: Glitch free switch between clock sources
module dct_clock_time_base
  import dct_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic crystal_in,
  input wire logic rc_clk_in,
  input wire logic test_hs_clk_out,
  output logic sys_clk_out,
  output logic rc_osc_enable,
  output logic crystal_osc_enable,
  output logic supply_boost_ctrl,
  output logic [DCT_TICK_N-1:0] tick_irq,
  output logic wdt_clk_16hz,
  output logic [4:0] buzzer_taps,
  output logic port_sample_64hz,
  output logic [1:0] reset_taps,
  output logic [3:0] capture_taps
);

  typedef struct packed {
    logic [DCT_DIV_W-1:0] div;
    logic crys_prev;
    logic crys_en;
    logic [DCT_REG_W-1:0] clk_select;
    dct_src_t src;
    logic sys_clk;
    logic rc_en;
    logic boost;
    logic [DCT_TICK_N-1:0] tick;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [DCT_REG_W-1:0] w_data;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dct_state_t;

  dct_state_t st;
  dct_state_t next_st;

  // R21 status register address
  // Word aligned address to register select
  function automatic dct_sel_t decode_addr(input logic [7:0] addr);
    if (addr == DCT_ADDR_TICK_STATUS) begin
      decode_addr = DCT_SEL_TICK;
    end else if (addr == DCT_ADDR_CLK_SELECT) begin
      decode_addr = DCT_SEL_CLK;
    end else begin
      decode_addr = DCT_SEL_NONE;
    end
  endfunction : decode_addr

  logic fast_sel;
  logic crys_fall;
  logic do_write;
  dct_sel_t wr_sel;
  dct_sel_t rd_sel;
  logic [DCT_DIV_W-1:0] fall;

  // Next state of divider, clock switch and bus slave
  always_comb begin
    next_st = st;
    fast_sel = st.clk_select[DCT_FAST_SEL_BIT];
    crys_fall = st.crys_prev & ~crystal_in;
    next_st.crys_prev = crystal_in;
    // Write address and data taken in either order
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_got = 1'b1;
      next_st.w_data = s_axi_wdata[DCT_REG_W-1:0];
      next_st.w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    do_write = st.aw_got && st.w_got && !st.bvalid;
    wr_sel = decode_addr(st.aw_addr);
    // R9 crystal divider
    // R10 count on falling edge
    if (crys_fall) begin
      next_st.div = st.div + 15'h0001;
    end
    if (do_write) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = (wr_sel == DCT_SEL_NONE) ? DCT_RESP_SLVERR : DCT_RESP_OKAY;
      // R18 clear low stages
      if (wr_sel == DCT_SEL_TICK) begin
        next_st.div[DCT_TAP_1HZ:DCT_TAP_8HZ] = 4'h0;
      end
      // R8 select register store
      if (wr_sel == DCT_SEL_CLK && st.w_lane0) begin
        next_st.clk_select = st.w_data;
      end
    end
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready = !next_st.w_got && !next_st.bvalid;
    // R11 falling tap ticks
    // R19 cleared 4 Hz and 1 Hz stages tick
    // R22 one request per tap
    fall = st.div & ~next_st.div;
    next_st.tick = {fall[DCT_TAP_1HZ], fall[DCT_TAP_4HZ], fall[DCT_TAP_16HZ], fall[DCT_TAP_32HZ],
      fall[DCT_TAP_256HZ]};
    // Read channel, one read at a time
    rd_sel = decode_addr(s_axi_araddr);
    if (s_axi_rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = (rd_sel == DCT_SEL_NONE) ? DCT_RESP_SLVERR : DCT_RESP_OKAY;
      next_st.rdata = 32'h0000_0000;
      // R17 status read
      if (rd_sel == DCT_SEL_TICK) begin
        next_st.rdata[DCT_REG_W-1:0] = st.div[DCT_TAP_1HZ:DCT_TAP_8HZ];
      end else if (rd_sel == DCT_SEL_CLK) begin
        next_st.rdata[DCT_REG_W-1:0] = st.clk_select;
      end
    end
    next_st.arready = !next_st.rvalid;
    // R3 RC runs only when needed
    next_st.rc_en = fast_sel || test_hs_clk_out;
    // R5 supply raised with select
    next_st.boost = fast_sel;
    // R4 crystal kept enabled
    next_st.crys_en = 1'b1;
    // R23 switch only through low phases
    unique case (st.src)
      DCT_SRC_CRYS: begin
        next_st.sys_clk = crystal_in;
        if (fast_sel && !crystal_in) begin
          next_st.src = DCT_SRC_GAP_TO_RC;
          next_st.sys_clk = 1'b0;
        end
      end
      DCT_SRC_GAP_TO_RC: begin
        next_st.sys_clk = 1'b0;
        if (!fast_sel) begin
          next_st.src = DCT_SRC_GAP_TO_CRYS;
        end else if (!rc_clk_in) begin
          next_st.src = DCT_SRC_RC;
        end
      end
      DCT_SRC_RC: begin
        next_st.sys_clk = rc_clk_in;
        if (!fast_sel && !rc_clk_in) begin
          next_st.src = DCT_SRC_GAP_TO_CRYS;
          next_st.sys_clk = 1'b0;
        end
      end
      DCT_SRC_GAP_TO_CRYS: begin
        next_st.sys_clk = 1'b0;
        if (fast_sel) begin
          next_st.src = DCT_SRC_GAP_TO_RC;
        end else if (!crystal_in) begin
          next_st.src = DCT_SRC_CRYS;
        end
      end
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // R2 crystal after reset
      st <= '0;
      st.div <= DCT_DIV_RST;
      st.clk_select <= DCT_CLK_SELECT_RST;
      st.src <= DCT_SRC_CRYS;
      st.crys_en <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Bus outputs
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  // R1 selected clock out
  assign sys_clk_out = st.sys_clk;
  assign rc_osc_enable = st.rc_en;
  // R4 crystal never stopped
  assign crystal_osc_enable = st.crys_en;
  assign supply_boost_ctrl = st.boost;
  assign tick_irq = st.tick;
  // R12 watchdog clock
  assign wdt_clk_16hz = st.div[DCT_TAP_16HZ];
  // R13 buzzer taps
  assign buzzer_taps = {st.div[DCT_TAP_1HZ], st.div[DCT_TAP_8HZ], st.div[DCT_TAP_16HZ],
    st.div[DCT_TAP_2KHZ], st.div[DCT_TAP_4KHZ]};
  // R14 port sampling
  assign port_sample_64hz = st.div[DCT_TAP_64HZ];
  // R15 reset circuit taps
  assign reset_taps = {st.div[DCT_TAP_1HZ], st.div[DCT_TAP_8HZ]};
  // R16 capture taps
  assign capture_taps = {st.div[DCT_TAP_256HZ], st.div[DCT_TAP_128HZ], st.div[DCT_TAP_64HZ],
    st.div[DCT_TAP_32HZ]};

  default clocking dct_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // R2 select cleared at reset
  sel_reset_clear_a: assert property ($past(!aresetn) |-> !st.clk_select[DCT_FAST_SEL_BIT]) // R2
    else $error("Clock select not cleared by reset");
  // R3 RC enable follows select and test
  rc_enable_gate_a: assert property (!st.clk_select[DCT_FAST_SEL_BIT] && !test_hs_clk_out |=> !rc_osc_enable) // R3
    else $error("RC oscillator enabled while unused");
  // R5 boost tied to select
  boost_follows_sel_a: assert property ($rose(st.clk_select[DCT_FAST_SEL_BIT]) |=> supply_boost_ctrl) // R5
    else $error("Supply boost not raised with fast clock");
  // R10 divider steps by one
  div_count_step_a: assert property (st.crys_prev && !crystal_in && !do_write |=> st.div == $past(st.div) + 15'h0001) // R10
    else $error("Divider did not step on crystal fall");
  // R18 write clears low stages
  status_write_clear_a: assert property (do_write && wr_sel == DCT_SEL_TICK |=> st.div[DCT_TAP_1HZ:DCT_TAP_8HZ] == 4'h0) // R18
    else $error("Status write did not clear low stages");
  // R19 cleared high stage ticks
  clear_tick_1hz_a: assert property (do_write && wr_sel == DCT_SEL_TICK && st.div[DCT_TAP_1HZ] |=> tick_irq[4]) // R19
    else $error("Clearing a set 1 Hz stage gave no tick");
  // R11 tick on falling tap
  fall_tick_256_a: assert property ($fell(st.div[DCT_TAP_256HZ]) |-> tick_irq[0] ##1 !tick_irq[0]) // R11
    else $error("256 Hz tick missing or not one cycle");
  // R17 status read data
  read_status_data_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == DCT_ADDR_TICK_STATUS // R17
    |=> s_axi_rvalid && s_axi_rdata[3:0] == $past(st.div[DCT_TAP_1HZ:DCT_TAP_8HZ]))
    else $error("Status read returned wrong stages");
  // R23 source change passes through low clock
  switch_low_gap_a: assert property (st.src != $past(st.src) |-> !sys_clk_out) // R23
    else $error("Clock source changed while output high");

  // R4 crystal kept on
  crys_osc_on_a: assert property (crystal_osc_enable) // R4
    else $error("Crystal oscillator enable dropped");
  // R1 crystal drives clock
  sys_clk_crys_a: assert property (st.src == DCT_SRC_CRYS && next_st.src == DCT_SRC_CRYS // R1
    |=> sys_clk_out == $past(crystal_in))
    else $error("System clock does not follow crystal");
  // R1 RC drives clock
  sys_clk_rc_a: assert property (st.src == DCT_SRC_RC && next_st.src == DCT_SRC_RC // R1
    |=> sys_clk_out == $past(rc_clk_in))
    else $error("System clock does not follow RC clock");
  // R5 boost dropped with select
  boost_drop_a: assert property (!st.clk_select[DCT_FAST_SEL_BIT] |=> !supply_boost_ctrl) // R5
    else $error("Supply boost raised without fast clock");

  // R11 remaining tap ticks
  fall_tick_32_a: assert property ($fell(st.div[DCT_TAP_32HZ]) |-> tick_irq[1]) // R11
    else $error("32 Hz tick missing");
  fall_tick_16_a: assert property ($fell(st.div[DCT_TAP_16HZ]) |-> tick_irq[2]) // R11
    else $error("16 Hz tick missing");
  fall_tick_4_a: assert property ($fell(st.div[DCT_TAP_4HZ]) |-> tick_irq[3]) // R11
    else $error("4 Hz tick missing");
  fall_tick_1_a: assert property ($fell(st.div[DCT_TAP_1HZ]) |-> tick_irq[4]) // R11
    else $error("1 Hz tick missing");
  // R22 request is one pulse
  tick_1hz_pulse_a: assert property (tick_irq[4] |=> !tick_irq[4]) // R22
    else $error("1 Hz tick longer than one cycle");

  // R8 select stored with lane 0
  select_write_a: assert property (do_write && wr_sel == DCT_SEL_CLK && st.w_lane0 // R8
    |=> st.clk_select == $past(st.w_data))
    else $error("Select register not written");
  // R8 select kept without lane 0
  select_keep_a: assert property (do_write && wr_sel == DCT_SEL_CLK && !st.w_lane0 |=> $stable(st.clk_select)) // R8
    else $error("Select register written without strobe");

  // Bus handshake holds and refusals
  write_resp_after_a: assert property (do_write |=> s_axi_bvalid)
    else $error("Write response missing");
  write_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write accepted while response pending");
  read_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read accepted while data pending");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response not held");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data not held");

  status_write_c: cover property (do_write && wr_sel == DCT_SEL_TICK && st.div[DCT_TAP_4HZ]);
  switch_to_rc_c: cover property (st.src == DCT_SRC_GAP_TO_RC ##[1:50] st.src == DCT_SRC_RC);
  switch_to_crys_c: cover property (st.src == DCT_SRC_GAP_TO_CRYS ##[1:300] st.src == DCT_SRC_CRYS);
  tick_one_hz_c: cover property (tick_irq[4]);
  test_rc_on_c: cover property (test_hs_clk_out && !st.clk_select[DCT_FAST_SEL_BIT] ##1 rc_osc_enable);

endmodule : dct_clock_time_base

// ### hdl/dct_pkg.sv
// Package with register map, divider taps and reset values of the clock and time base block
package dct_pkg;
  // Register indices; each register takes one aligned word at four times its index
  localparam logic [5:0] DCT_IDX_TICK_STATUS = 6'h0f;
  localparam logic [5:0] DCT_IDX_CLK_SELECT = 6'h09;
  localparam logic [7:0] DCT_ADDR_TICK_STATUS = {DCT_IDX_TICK_STATUS, 2'b00};
  localparam logic [7:0] DCT_ADDR_CLK_SELECT = {DCT_IDX_CLK_SELECT, 2'b00};
  // Field positions
  localparam int DCT_FAST_SEL_BIT = 0;
  localparam int DCT_REG_W = 4;
  // Divider chain, stage n toggles at 32768 / 2^(n+1) Hz
  localparam int DCT_DIV_W = 15;
  localparam int DCT_TAP_4KHZ = 2;
  localparam int DCT_TAP_2KHZ = 3;
  localparam int DCT_TAP_256HZ = 6;
  localparam int DCT_TAP_128HZ = 7;
  localparam int DCT_TAP_64HZ = 8;
  localparam int DCT_TAP_32HZ = 9;
  localparam int DCT_TAP_16HZ = 10;
  localparam int DCT_TAP_8HZ = 11;
  localparam int DCT_TAP_4HZ = 12;
  localparam int DCT_TAP_2HZ = 13;
  localparam int DCT_TAP_1HZ = 14;
  localparam int DCT_TICK_N = 5;
  // Reset values
  localparam logic [DCT_DIV_W-1:0] DCT_DIV_RST = 15'h0000;
  localparam logic [DCT_REG_W-1:0] DCT_CLK_SELECT_RST = 4'h0;
  // Bus responses
  localparam logic [1:0] DCT_RESP_OKAY = 2'h0;
  localparam logic [1:0] DCT_RESP_SLVERR = 2'h2;
  // Clock source switch states
  typedef enum logic [1:0] {
    DCT_SRC_CRYS,
    DCT_SRC_GAP_TO_RC,
    DCT_SRC_RC,
    DCT_SRC_GAP_TO_CRYS
  } dct_src_t;
  // Register select from address decode
  typedef enum logic [1:0] {
    DCT_SEL_NONE,
    DCT_SEL_TICK,
    DCT_SEL_CLK
  } dct_sel_t;
endpackage : dct_pkg

// ### bench/dct_osc_model.sv
// Oscillator model that drives the crystal and RC clock levels
`timescale 1ns/1ps
module dct_osc_model (
  input wire logic aclk,
  input wire logic rc_osc_enable,
  output logic crystal_in,
  output logic rc_clk_in
);
  logic ph;
  initial begin
    crystal_in = 1'b0;
    rc_clk_in = 1'b1;
    ph = 1'b0;
  end
  // Crystal runs free, one period every four cycles
  always @(posedge aclk) begin
    ph <= ~ph;
    if (ph) crystal_in <= ~crystal_in;
  end
  // RC runs only when enabled, pin pulled high when stopped
  always @(posedge aclk) begin
    rc_clk_in <= rc_osc_enable ? ~rc_clk_in : 1'b1;
  end
endmodule : dct_osc_model

// ### bench/dual_clock_and_time_base_tb_top.sv
// Self-checking bench for the clock select and time base block
`timescale 1ns/1ps
module dual_clock_and_time_base_tb_top;
  import dct_pkg::*;
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready, test_hs, clr_arm, mon, crys_q, rc_q;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, cap;
  logic awready, wready, bvalid, arready, rvalid, sys_clk, rc_en, crys_en, boost, wdt, p64, crys, rc;
  logic [1:0] bresp, rresp, rst_t, r;
  logic [4:0] tick, buz, etick;
  logic [14:0] cnt;
  int fails = 0;
  int checked = 0;
  always #10 aclk = ~aclk;
  dct_clock_time_base dct_clock_time_base_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .crystal_in(crys), .rc_clk_in(rc), .test_hs_clk_out(test_hs), .sys_clk_out(sys_clk),
    .rc_osc_enable(rc_en), .crystal_osc_enable(crys_en), .supply_boost_ctrl(boost), .tick_irq(tick),
    .wdt_clk_16hz(wdt), .buzzer_taps(buz), .port_sample_64hz(p64), .reset_taps(rst_t), .capture_taps(cap));
  dct_osc_model dct_osc_model_i (.aclk(aclk), .rc_osc_enable(rc_en), .crystal_in(crys), .rc_clk_in(rc));
  // Reference divider counting crystal falls, with status clear
  always @(posedge aclk) begin : ref_div
    logic [14:0] nx;
    nx = cnt + {14'h0, crys_q & ~crys};
    if (clr_arm) nx[14:11] = 4'h0;
    etick <= aresetn ? {cnt[14] & ~nx[14], cnt[12] & ~nx[12], cnt[10] & ~nx[10], cnt[9] & ~nx[9],
      cnt[6] & ~nx[6]} : 5'h00;
    cnt <= aresetn ? nx : 15'h0000;
    crys_q <= aresetn ? crys : 1'b0;
    rc_q <= rc;
  end
  // Tick and tap outputs checked every cycle
  always @(negedge aclk) begin
    if (mon) begin
      `CHK(tick, etick)
      `CHK({wdt, buz, p64, rst_t, cap}, {cnt[10], cnt[14], cnt[11], cnt[10], cnt[3], cnt[2], cnt[8], cnt[14], cnt[11], cnt[6], cnt[7], cnt[8], cnt[9]})
    end
  end
  task automatic give_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic hang;
    fails++;
    $display("[ERR] %0t wait ran out", $time);
    give_verdict();
  endtask : hang
  // Write cycle; arms the reference clear for the effect edge
  task automatic wr(input logic [7:0] a, input logic [31:0] dd, input logic [3:0] s);
    int n;
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= dd;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awready && !ad) begin ad = 1'b1; awvalid <= 1'b0; end
      if (wready && !wd) begin wd = 1'b1; wvalid <= 1'b0; end
      if (++n > 50) hang();
    end
    clr_arm <= (a == DCT_ADDR_TICK_STATUS);
    do begin @(posedge aclk); clr_arm <= 1'b0; if (++n > 99) hang(); end while (!bvalid);
    bready <= 1'b0;
    r = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin @(posedge aclk); if (++n > 50) hang(); end while (!arready);
    arvalid <= 1'b0;
    do begin @(posedge aclk); if (++n > 99) hang(); end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : rd
  task automatic sys_chk(input logic src_rc);
    repeat (12) @(posedge aclk);
    repeat (20) begin @(negedge aclk); `CHK(sys_clk, src_rc ? rc_q : crys_q) end
  endtask : sys_chk
  task automatic t_reset;
    rd(DCT_ADDR_CLK_SELECT);
    `CHK({r, d}, {DCT_RESP_OKAY, 32'h0})
    rd(DCT_ADDR_TICK_STATUS);
    `CHK({r, d}, {DCT_RESP_OKAY, 32'h0})
    `CHK({rc_en, crys_en, boost}, 3'b010)
    sys_chk(1'b0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_fast;
    wr(DCT_ADDR_CLK_SELECT, 32'h1, 4'h1);
    @(negedge aclk);
    `CHK({r, boost, rc_en, crys_en}, {DCT_RESP_OKAY, 3'b111})
    sys_chk(1'b1);
    wr(DCT_ADDR_CLK_SELECT, 32'h0, 4'h0);
    rd(DCT_ADDR_CLK_SELECT);
    `CHK(d, 32'h1)
    wr(DCT_ADDR_CLK_SELECT, 32'h0, 4'h1);
    repeat (2) @(negedge aclk);
    `CHK({boost, rc_en}, 2'b00)
    sys_chk(1'b0);
    @(posedge aclk);
    test_hs <= 1'b1;
    repeat (2) @(negedge aclk);
    `CHK(rc_en, 1'b1)
    @(posedge aclk);
    test_hs <= 1'b0;
    $display("select test done");
  endtask : t_fast
  task automatic t_unmapped;
    rd(8'h00);
    `CHK({r, d}, {DCT_RESP_SLVERR, 32'h0})
    wr(8'h00, 32'h1, 4'hf);
    `CHK(r, DCT_RESP_SLVERR)
    $display("unmapped test done");
  endtask : t_unmapped
  task automatic t_status;
    int n;
    n = 0;
    while (!(cnt[12] && cnt[11])) begin @(posedge aclk); if (++n > 40000) hang(); end
    rd(DCT_ADDR_TICK_STATUS);
    `CHK(d, {28'h0, cnt[14:11]})
    wr(DCT_ADDR_TICK_STATUS, 32'hf, 4'h0);
    rd(DCT_ADDR_TICK_STATUS);
    `CHK(d, 32'h0)
    $display("status test done");
  endtask : t_status
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, test_hs, clr_arm, mon, crys_q, rc_q} = 10'h000;
    {awaddr, araddr, wdata, wstrb, cnt} = 67'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    mon <= 1'b1;
    t_reset();
    t_fast();
    t_unmapped();
    t_status();
    give_verdict();
  end
endmodule : dual_clock_and_time_base_tb_top
